// [hw/fault_flags_cfg.svh]
// Overview of operation
// RL1: Read-only 16-bit fault word at 0x00/0x01
// RL2: Low-voltage bit follows supply in self-clearing variant
// RL3: Latching variant holds until reset or clear
// RL4: Measurement timeout sets high bit 1
// RL5: Successful measurement clears timeout and abnormal flags
// RL6: Later variant flags bad samples plus self-diagnostic
// RL7: Invalid scaling factor sets high bit 7
// RL8: Scale flag clears after valid write then reset
// RL9: Unknown register access sets low bit 1
// RL10: Internal failure sets low bit 4
// RL11: Front-end, parameter, calibration, range failures flagged
// RL12: Reserved high bits 3..6 read zero
`ifndef FAULT_FLAGS_CFG_SVH
`define FAULT_FLAGS_CFG_SVH

`define FF_TARGET_ADDR   7'h68
`define FF_REG_HIGH      8'h00
`define FF_REG_LOW       8'h01
`define FF_RSVD_HIGH     4'h0
`define FF_RSVD_LOW      2'h0
`define FF_BIT_LAST      3'h7
`define FF_NUM_FLAGS     10
`define FF_RD_DIR        1'b1

// Flag vector indices
`define FV_LOWV          0
`define FV_TMO           1
`define FV_ABN           2
`define FV_SCALE         3
`define FV_AFE           4
`define FV_I2C           5
`define FV_ALGO          6
`define FV_CAL           7
`define FV_DIAG          8
`define FV_RANGE         9

`endif

// [hw/fault_flags_pkg.sv]
package fault_flags_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ADDR_AK = 3'b010,
    ST_WR_BYTE = 3'b011,
    ST_WR_AK   = 3'b100,
    ST_RD_BYTE = 3'b101,
    ST_RD_AK   = 3'b110
  } tgt_state_t;
endpackage : fault_flags_pkg

// [hw/pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  // First stage is read by the second stage only
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '1;
      q        <= '1;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

// [hw/flag_cell.sv]
`timescale 1ns/10ps
`default_nettype none
module flag_cell #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] q
);
  // Set wins over clear so an event in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= set | (q & ~clr);
    end
  end
endmodule : flag_cell
`default_nettype wire

// [hw/sensor_error_status_flags.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fault_flags_cfg.svh"
module sensor_error_status_flags
  import fault_flags_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  output logic [7:0]      REG_ADDR,
  input  wire logic       REG_ADDR_KNOWN,
  input  wire logic [7:0] REG_RDATA,
  output logic            REG_WR_STB,
  output logic [7:0]      REG_WDATA,
  input  wire logic       LATCH_VARIANT,
  input  wire logic       EXT_DIAG_VARIANT,
  input  wire logic       SCALE_CHECK_EN,
  input  wire logic       LOW_VOLT_DET,
  input  wire logic       MEAS_TIMEOUT,
  input  wire logic       MEAS_DONE_OK,
  input  wire logic       BAD_SAMPLE,
  input  wire logic       SCALE_INVALID,
  input  wire logic       SCALE_WRITE_OK,
  input  wire logic       DEVICE_RESET_CMD,
  input  wire logic       FAULT_CLEAR_WR,
  input  wire logic       AFE_INIT_FAIL,
  input  wire logic       PARAM_CORRUPT,
  input  wire logic       CAL_FAIL,
  input  wire logic       RANGE_ERR,
  input  wire logic       SELF_DIAG_FAIL,
  output logic [15:0]     FAULT_WORD
);

  // ---------------- Pin synchronisers and bus conditions
  logic [1:0] pins_sync;
  logic       scl_prev_reg;
  logic       sda_prev_reg;

  pin_sync #(.WIDTH(2)) u_pin_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_B),
    .d     ({SCL_IN, SDA_IN}),
    .q     (pins_sync)
  );
  wire scl       = pins_sync[1];
  wire sda       = pins_sync[0];
  wire scl_rise  = scl & ~scl_prev_reg;
  wire scl_fall  = ~scl & scl_prev_reg;
  wire start_det = scl & scl_prev_reg & sda_prev_reg & ~sda;
  wire stop_det  = scl & scl_prev_reg & ~sda_prev_reg & sda;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl;
      sda_prev_reg <= sda;
    end
  end

  // ---------------- Target state machine
  tgt_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [2:0] bit_cnt_reg;
  logic       got_byte_reg;
  logic       rd_dir_reg;
  logic       ptr_phase_reg;
  logic       wr_data_reg;
  logic       nack_reg;
  logic       sda_low_reg;
  logic [7:0] ptr_reg;
  logic       wr_stb_reg;
  logic [7:0] wdata_reg;
  logic       unknown_evt_reg;
  logic       ptr_chk_reg;
  logic [15:0] flag_word;

  wire own_hit   = (ptr_reg == `FF_REG_HIGH) || (ptr_reg == `FF_REG_LOW);
  wire [7:0] rd_byte = (ptr_reg == `FF_REG_HIGH) ? flag_word[15:8] :
                       (ptr_reg == `FF_REG_LOW)  ? flag_word[7:0]  : REG_RDATA;
  wire addr_match = (shift_reg[7:1] == `FF_TARGET_ADDR);
  wire byte_end   = scl_fall && got_byte_reg;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state_reg       <= ST_IDLE;
      shift_reg       <= 8'h00;
      tx_reg          <= 8'h00;
      bit_cnt_reg     <= 3'h0;
      got_byte_reg    <= 1'b0;
      rd_dir_reg      <= 1'b0;
      ptr_phase_reg   <= 1'b0;
      wr_data_reg     <= 1'b0;
      nack_reg        <= 1'b0;
      sda_low_reg     <= 1'b0;
      ptr_reg         <= 8'h00;
      wr_stb_reg      <= 1'b0;
      wdata_reg       <= 8'h00;
      unknown_evt_reg <= 1'b0;
      ptr_chk_reg     <= 1'b0;
    end else begin
      wr_stb_reg      <= 1'b0;
      ptr_chk_reg     <= 1'b0;
      // The outside map answers for a new pointer only once REG_ADDR shows it
      unknown_evt_reg <= ptr_chk_reg & ~(own_hit | REG_ADDR_KNOWN); // RL9
      if (start_det) begin
        state_reg     <= ST_ADDR;
        bit_cnt_reg   <= 3'h0;
        got_byte_reg  <= 1'b0;
        sda_low_reg   <= 1'b0;
      end else if (stop_det) begin
        state_reg     <= ST_IDLE;
        sda_low_reg   <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_WR_BYTE: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == `FF_BIT_LAST) begin
                got_byte_reg <= 1'b1;
              end
            end
            if (byte_end && state_reg == ST_ADDR) begin
              got_byte_reg <= 1'b0;
              if (addr_match) begin
                rd_dir_reg    <= (shift_reg[0] == `FF_RD_DIR);
                ptr_phase_reg <= (shift_reg[0] != `FF_RD_DIR);
                state_reg     <= ST_ADDR_AK;
                sda_low_reg   <= 1'b1;
              end else begin
                state_reg     <= ST_IDLE;
              end
            end else if (byte_end) begin
              got_byte_reg  <= 1'b0;
              state_reg     <= ST_WR_AK;
              sda_low_reg   <= 1'b1;
              wr_data_reg   <= ~ptr_phase_reg;
              if (ptr_phase_reg) begin
                ptr_reg         <= shift_reg;
                ptr_phase_reg   <= 1'b0;
                ptr_chk_reg     <= 1'b1; // RL9
              end else begin
                // Writes to the fault word are acknowledged but dropped
                wr_stb_reg      <= ~own_hit; // RL1
                wdata_reg       <= shift_reg;
                unknown_evt_reg <= ~(own_hit | REG_ADDR_KNOWN); // RL9
              end
            end
          end
          ST_ADDR_AK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (rd_dir_reg) begin
                tx_reg          <= rd_byte;
                sda_low_reg     <= ~rd_byte[7];
                ptr_reg         <= ptr_reg + 8'h01;
                unknown_evt_reg <= ~(own_hit | REG_ADDR_KNOWN); // RL9
                state_reg       <= ST_RD_BYTE;
              end else begin
                sda_low_reg     <= 1'b0;
                state_reg       <= ST_WR_BYTE;
              end
            end
          end
          ST_WR_AK: begin
            if (scl_fall) begin
              sda_low_reg <= 1'b0;
              bit_cnt_reg <= 3'h0;
              state_reg   <= ST_WR_BYTE;
              if (wr_data_reg) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          ST_RD_BYTE: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              tx_reg      <= {tx_reg[6:0], 1'b0};
              if (bit_cnt_reg == `FF_BIT_LAST) begin
                sda_low_reg <= 1'b0;
                state_reg   <= ST_RD_AK;
              end else begin
                sda_low_reg <= ~tx_reg[6];
              end
            end
          end
          ST_RD_AK: begin
            if (scl_rise) begin
              nack_reg <= sda;
            end
            // Controller NACK ends the read; a bare STOP also does
            if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (nack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                tx_reg          <= rd_byte;
                sda_low_reg     <= ~rd_byte[7];
                ptr_reg         <= ptr_reg + 8'h01;
                unknown_evt_reg <= ~(own_hit | REG_ADDR_KNOWN); // RL9
                state_reg       <= ST_RD_BYTE;
              end
            end
          end
          default: begin
            state_reg   <= ST_IDLE;
            sda_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end
  assign SDA_OUT    = 1'b0;
  assign SDA_OE     = sda_low_reg;
  assign REG_ADDR   = ptr_reg;
  assign REG_WR_STB = wr_stb_reg;
  assign REG_WDATA  = wdata_reg;

  // ---------------- Fault flags
  logic       scale_ok_pend_reg;
  logic [`FF_NUM_FLAGS-1:0] flag_set;
  logic [`FF_NUM_FLAGS-1:0] flag_clr;
  logic [`FF_NUM_FLAGS-1:0] flags;

  wire clr_evt     = DEVICE_RESET_CMD | FAULT_CLEAR_WR; // RL3
  wire ext_tmo     = EXT_DIAG_VARIANT & MEAS_TIMEOUT;
  wire ext_bad     = EXT_DIAG_VARIANT & BAD_SAMPLE; // RL6
  // Needs both a validated factor and a later reset; one alone is not enough
  wire scale_clear = DEVICE_RESET_CMD & scale_ok_pend_reg; // RL8

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      scale_ok_pend_reg <= 1'b0;
    end else if (DEVICE_RESET_CMD) begin
      scale_ok_pend_reg <= 1'b0;
    end else if (SCALE_WRITE_OK) begin
      scale_ok_pend_reg <= 1'b1; // RL8
    end
  end

  assign flag_set[`FV_LOWV]  = LOW_VOLT_DET; // RL2
  assign flag_clr[`FV_LOWV]  = LATCH_VARIANT ? clr_evt : ~LOW_VOLT_DET; // RL2 RL3
  assign flag_set[`FV_TMO]   = MEAS_TIMEOUT; // RL4
  assign flag_clr[`FV_TMO]   = MEAS_DONE_OK; // RL5
  assign flag_set[`FV_ABN]   = ext_bad; // RL6
  assign flag_clr[`FV_ABN]   = MEAS_DONE_OK; // RL5
  assign flag_set[`FV_SCALE] = SCALE_CHECK_EN & SCALE_INVALID; // RL7
  assign flag_clr[`FV_SCALE] = scale_clear; // RL8
  assign flag_set[`FV_AFE]   = AFE_INIT_FAIL; // RL11
  assign flag_clr[`FV_AFE]   = clr_evt;
  assign flag_set[`FV_I2C]   = unknown_evt_reg; // RL9
  assign flag_clr[`FV_I2C]   = clr_evt;
  assign flag_set[`FV_ALGO]  = PARAM_CORRUPT; // RL11
  assign flag_clr[`FV_ALGO]  = clr_evt;
  assign flag_set[`FV_CAL]   = CAL_FAIL; // RL11
  assign flag_clr[`FV_CAL]   = clr_evt;
  assign flag_set[`FV_DIAG]  = SELF_DIAG_FAIL | ext_bad | ext_tmo; // RL10 RL6
  assign flag_clr[`FV_DIAG]  = clr_evt;
  assign flag_set[`FV_RANGE] = RANGE_ERR; // RL11
  assign flag_clr[`FV_RANGE] = clr_evt;

  flag_cell #(.WIDTH(`FF_NUM_FLAGS)) u_flags (
    .clk   (SYS_CLK),
    .rst_n (RST_B),
    .set   (flag_set),
    .clr   (flag_clr),
    .q     (flags)
  );

  assign flag_word = {flags[`FV_SCALE], `FF_RSVD_HIGH, flags[`FV_ABN], // RL12
                      flags[`FV_TMO], flags[`FV_LOWV],
                      `FF_RSVD_LOW, flags[`FV_RANGE], flags[`FV_DIAG],
                      flags[`FV_CAL], flags[`FV_ALGO], flags[`FV_I2C],
                      flags[`FV_AFE]};
  assign FAULT_WORD = flag_word; // RL1

  // ---------------- Assertions
  property p_lowv_follow;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !LATCH_VARIANT && $changed(LOW_VOLT_DET) |=> FAULT_WORD[8] == $past(LOW_VOLT_DET);
  endproperty
  a_lowv_follow: assert property (p_lowv_follow) else $error("low-voltage bit not following"); // RL2
  property p_lowv_latch;
    @(posedge SYS_CLK) disable iff (!RST_B)
      LATCH_VARIANT && FAULT_WORD[8] && !clr_evt |=> FAULT_WORD[8];
  endproperty
  a_lowv_latch: assert property (p_lowv_latch) else $error("latched low-voltage bit lost"); // RL3
  property p_tmo_set;
    @(posedge SYS_CLK) disable iff (!RST_B)
      MEAS_TIMEOUT |=> FAULT_WORD[9];
  endproperty
  a_tmo_set: assert property (p_tmo_set) else $error("timeout bit not set"); // RL4
  property p_done_clear;
    @(posedge SYS_CLK) disable iff (!RST_B)
      MEAS_DONE_OK && !MEAS_TIMEOUT && !BAD_SAMPLE |=> !FAULT_WORD[9] && !FAULT_WORD[10];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("measurement flags not cleared"); // RL5
  property p_diag_pair;
    @(posedge SYS_CLK) disable iff (!RST_B)
      EXT_DIAG_VARIANT && (BAD_SAMPLE || MEAS_TIMEOUT) |=> FAULT_WORD[4] && (FAULT_WORD[9] || FAULT_WORD[10]);
  endproperty
  a_diag_pair: assert property (p_diag_pair) else $error("self-diagnostic bit missing"); // RL6
  property p_scale_hold;
    @(posedge SYS_CLK) disable iff (!RST_B)
      FAULT_WORD[15] && !(DEVICE_RESET_CMD && scale_ok_pend_reg) |=> FAULT_WORD[15];
  endproperty
  a_scale_hold: assert property (p_scale_hold) else $error("scale bit cleared early"); // RL8
  property p_scale_set;
    @(posedge SYS_CLK) disable iff (!RST_B)
      SCALE_CHECK_EN && SCALE_INVALID |=> FAULT_WORD[15];
  endproperty
  a_scale_set: assert property (p_scale_set) else $error("scale bit not set"); // RL7
  property p_i2c_err;
    @(posedge SYS_CLK) disable iff (!RST_B)
      unknown_evt_reg ##1 !clr_evt |-> FAULT_WORD[1] ##1 FAULT_WORD[1];
  endproperty
  a_i2c_err: assert property (p_i2c_err) else $error("bus error bit not held"); // RL9
  property p_reserved;
    @(posedge SYS_CLK) disable iff (!RST_B)
      FAULT_WORD[14:11] == `FF_RSVD_HIGH;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // RL12
  property p_ro_word;
    @(posedge SYS_CLK) disable iff (!RST_B)
      REG_WR_STB |-> REG_ADDR != `FF_REG_HIGH && REG_ADDR != `FF_REG_LOW;
  endproperty
  a_ro_word: assert property (p_ro_word) else $error("write strobe on fault word"); // RL1
  property p_diag_fail;
    @(posedge SYS_CLK) disable iff (!RST_B)
      SELF_DIAG_FAIL |=> FAULT_WORD[4];
  endproperty
  a_diag_fail: assert property (p_diag_fail) else $error("internal failure bit not set"); // RL10
endmodule : sensor_error_status_flags
`default_nettype wire

// [tb/host_bus.sv]
`timescale 1ns/10ps
`default_nettype none
module host_bus #(
  parameter int Q = 8
) (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic host_low = 1'b0;
  initial scl = 1'b1;
  // Pull-up on the line: high unless the host or the device pulls it low
  assign sda = ~(host_low | sda_oe);
  // Host changes its lines just after an edge and holds them for Q cycles
  task automatic step(input logic s, input logic l);
    scl <= s;
    host_low <= l;
    repeat (Q) @(posedge clk);
  endtask : step
  task automatic start();
    step(scl, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : stop
  task automatic bitio(input logic b, output logic r);
    step(1'b0, ~b);
    step(1'b1, ~b);
    r = sda;
    step(1'b0, ~b);
  endtask : bitio
  // Data goes out MSB first; last is the host's own ninth bit
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bitio(d[i], r[i]);
    bitio(last, ack);
  endtask : xfer
endmodule : host_bus
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int LATCH = 0, EXTD = 1, SCEN = 2, LOWV = 3, TMO = 4, DONE = 5, BAD = 6;
  localparam int SCINV = 7, SWOK = 8, RCMD = 9, CLR = 10;
  logic        SYS_CLK = 1'b0;
  logic        RST_B   = 1'b0;
  logic [15:0] ev      = 16'h0000;
  logic        scl, sda, SDA_OE, REG_WR_STB;
  logic [7:0]  REG_ADDR, REG_WDATA;
  logic [15:0] FAULT_WORD;
  logic [15:0] n_stb   = 16'h0000;
  int          n_fail  = 0;
  int          checks  = 0;
  int          lb[5]   = '{0, 2, 3, 5, 4};

  always #25 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (REG_WR_STB === 1'b1) n_stb <= n_stb + 16'h0001;

  host_bus i_host_bus (.clk(SYS_CLK), .sda_oe(SDA_OE), .scl(scl), .sda(sda));

  sensor_error_status_flags i_sensor_error_status_flags (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE(SDA_OE), .REG_ADDR(REG_ADDR),
    .REG_ADDR_KNOWN(REG_ADDR == 8'h06), .REG_RDATA(8'h5a),
    .REG_WR_STB(REG_WR_STB), .REG_WDATA(REG_WDATA),
    .LATCH_VARIANT(ev[LATCH]), .EXT_DIAG_VARIANT(ev[EXTD]), .SCALE_CHECK_EN(ev[SCEN]),
    .LOW_VOLT_DET(ev[LOWV]), .MEAS_TIMEOUT(ev[TMO]), .MEAS_DONE_OK(ev[DONE]),
    .BAD_SAMPLE(ev[BAD]), .SCALE_INVALID(ev[SCINV]), .SCALE_WRITE_OK(ev[SWOK]),
    .DEVICE_RESET_CMD(ev[RCMD]), .FAULT_CLEAR_WR(ev[CLR]), .AFE_INIT_FAIL(ev[11]),
    .PARAM_CORRUPT(ev[12]), .CAL_FAIL(ev[13]), .RANGE_ERR(ev[14]),
    .SELF_DIAG_FAIL(ev[15]), .FAULT_WORD(FAULT_WORD));

  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // The value is taken at the call, so callers hand it over settled; the wait spaces the next step
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    repeat (2) @(negedge SYS_CLK);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic lvl(input int i, input logic v);
    @(posedge SYS_CLK);
    ev[i] <= v;
    @(posedge SYS_CLK);
    // Flags update at the edge that samples the input; read them after it
    @(negedge SYS_CLK);
  endtask : lvl

  task automatic pulse(input int i);
    lvl(i, 1'b1);
    lvl(i, 1'b0);
  endtask : pulse

  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic nd);
    logic [7:0] r;
    logic [2:0] a;
    a = 3'b000;
    i_host_bus.start();
    i_host_bus.xfer(8'hd0, 1'b1, r, a[0]);
    i_host_bus.xfer(p, 1'b1, r, a[1]);
    if (nd) i_host_bus.xfer(d, 1'b1, r, a[2]);
    i_host_bus.stop();
    chk("write acks", 16'h0000, {13'h0000, a});
  endtask : wr

  task automatic rd_word(input logic [15:0] e);
    logic [7:0] hi, lo, r;
    logic [3:0] a;
    logic       n;
    i_host_bus.start();
    i_host_bus.xfer(8'hd0, 1'b1, r, a[0]);
    i_host_bus.xfer(8'h00, 1'b1, r, a[1]);
    i_host_bus.start();
    i_host_bus.xfer(8'hd1, 1'b1, r, a[2]);
    i_host_bus.xfer(8'hff, 1'b0, hi, a[3]);
    i_host_bus.xfer(8'hff, 1'b1, lo, n);
    i_host_bus.stop();
    chk("read acks", 16'h0000, {12'h000, a});
    chk("bus fault word", e, {hi, lo});
  endtask : rd_word

  initial begin
    repeat (50000) @(posedge SYS_CLK);
    n_fail++;
    $display("mismatch run length expected finish seen timeout");
    complete_run();
  end

  initial begin
    repeat (4) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    chk("reset word", 16'h0000, FAULT_WORD);
    lvl(LOWV, 1'b1);
    chk("lowv set", 16'h0100, FAULT_WORD);
    lvl(LOWV, 1'b0);
    chk("lowv self clear", 16'h0000, FAULT_WORD);
    $display("test low voltage self clear done");
    lvl(LATCH, 1'b1);
    pulse(LOWV);
    chk("lowv latched", 16'h0100, FAULT_WORD);
    pulse(CLR);
    chk("lowv clear write", 16'h0000, FAULT_WORD);
    pulse(LOWV);
    pulse(RCMD);
    chk("lowv reset cmd", 16'h0000, FAULT_WORD);
    pulse(LOWV);
    @(posedge SYS_CLK) RST_B <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    chk("lowv power cycle", 16'h0000, FAULT_WORD);
    $display("test low voltage latch done");
    pulse(BAD);
    chk("bad sample early variant", 16'h0000, FAULT_WORD);
    pulse(TMO);
    chk("timeout", 16'h0200, FAULT_WORD);
    lvl(EXTD, 1'b1);
    pulse(BAD);
    chk("bad sample with diag", 16'h0610, FAULT_WORD);
    pulse(DONE);
    chk("measurement ok", 16'h0010, FAULT_WORD);
    pulse(CLR);
    pulse(TMO);
    chk("timeout with diag", 16'h0210, FAULT_WORD);
    pulse(DONE);
    pulse(CLR);
    chk("measurement flags clear", 16'h0000, FAULT_WORD);
    $display("test measurement flags done");
    lvl(SCINV, 1'b1);
    chk("scale check off", 16'h0000, FAULT_WORD);
    lvl(SCEN, 1'b1);
    chk("scale invalid", 16'h8000, FAULT_WORD);
    lvl(SCINV, 1'b0);
    pulse(RCMD);
    chk("scale reset only", 16'h8000, FAULT_WORD);
    pulse(SWOK);
    chk("scale write only", 16'h8000, FAULT_WORD);
    pulse(RCMD);
    chk("scale write then reset", 16'h0000, FAULT_WORD);
    $display("test scale factor done");
    for (int k = 0; k < 5; k++) begin
      pulse(11 + k);
      chk("low byte flag", 16'h0001 << lb[k], FAULT_WORD);
      pulse(CLR);
      chk("low byte clear", 16'h0000, FAULT_WORD);
    end
    $display("test low byte flags done");
    pulse(LOWV);
    pulse(13);
    rd_word(16'h0108);
    wr(8'h00, 8'hff, 1'b1);
    rd_word(16'h0108);
    chk("strobes after own write", 16'h0000, n_stb);
    wr(8'h06, 8'h3c, 1'b1);
    chk("strobes after known write", 16'h0001, n_stb);
    chk("write data", 16'h003c, {8'h00, REG_WDATA});
    chk("pointer after write", 16'h0007, {8'h00, REG_ADDR});
    chk("known address", 16'h0108, FAULT_WORD);
    wr(8'h50, 8'h00, 1'b0);
    chk("unknown address", 16'h010a, FAULT_WORD);
    $display("test bus access done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
